/* logic/soec_host.sv */
`timescale 1ns/10ps
module soec_host #(
   parameter int unsigned HALF_CYC = soec_pkg::HALF_CYC_MIN
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // link
   soec_if.host link
);
   typedef enum logic [1:0] {
      SOEC_IDLE = 2'b00,
      SOEC_LOW = 2'b01,
      SOEC_HIGH = 2'b10
   } soec_host_state_t;

   // timer is eight bits wide, and too short a half period breaks the strobe limits
   if (HALF_CYC < soec_pkg::HALF_CYC_MIN || HALF_CYC > 255) begin : g_half_cyc_check
      $error("soec_host: HALF_CYC out of range");
   end

   soec_host_state_t state_q;
   logic [10:0] config_q;
   logic [3:0] pulse_q;
   logic [7:0] timer_q;
   logic done_q;
   logic strobe_q;
   logic sel_q;
   logic sin_q;
   logic [31:0] rdata_q;
   logic start;

   assign start = wr && addr == soec_pkg::ADDR_CMD && wdata[soec_pkg::CMD_PROGRAM_BIT]
      && state_q == SOEC_IDLE && clk_en;

   //////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         config_q <= soec_pkg::CFG_RESET;
      end else if (clk_en && wr && addr == soec_pkg::ADDR_CONFIG) begin
         config_q <= wdata[10:0];
      end
   end

   // pulse 0 resets, pulses 1..11 shift, pulse 12 loads
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= SOEC_IDLE;
         pulse_q <= 4'h0;
         timer_q <= 8'h00;
         strobe_q <= 1'b0;
         sel_q <= 1'b0;
         sin_q <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            SOEC_IDLE: begin
               if (start) begin
                  state_q <= SOEC_LOW;
                  pulse_q <= 4'h0;
                  timer_q <= 8'h00;
                  sel_q <= 1'b0;
               end else if (wr && addr == soec_pkg::ADDR_CMD
                            && wdata[soec_pkg::CMD_STANDARD_BIT]) begin
                  sel_q <= 1'b0;
                  sin_q <= wdata[soec_pkg::CMD_CHOICE_BIT];
               end
            end
            SOEC_LOW: begin
               if (timer_q + 8'h1 >= 8'(HALF_CYC)) begin
                  state_q <= SOEC_HIGH;
                  timer_q <= 8'h00;
                  strobe_q <= 1'b1;
               end else begin
                  timer_q <= timer_q + 8'h1;
               end
            end
            SOEC_HIGH: begin
               if (timer_q + 8'h1 >= 8'(HALF_CYC)) begin
                  strobe_q <= 1'b0;
                  timer_q <= 8'h00;
                  if (pulse_q == 4'(soec_pkg::LOAD_PULSE)) begin
                     state_q <= SOEC_IDLE;
                  end else begin
                     state_q <= SOEC_LOW;
                     pulse_q <= pulse_q + 4'h1;
                     sel_q <= 1'b1;
                     if (pulse_q < 4'(soec_pkg::CFG_BITS)) begin
                        sin_q <= config_q[pulse_q];
                     end
                  end
               end else begin
                  timer_q <= timer_q + 8'h1;
               end
            end
            default: begin
               state_q <= SOEC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
      end else if (clk_en) begin
         if (state_q == SOEC_HIGH && pulse_q == 4'(soec_pkg::LOAD_PULSE)
             && timer_q + 8'h1 >= 8'(HALF_CYC)) begin
            done_q <= 1'b1;
         end else if (start) begin
            done_q <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         rdata_q <= 32'h0000_0000;
         if (rd) begin
            if (addr == soec_pkg::ADDR_CONFIG) begin
               rdata_q <= {21'h000000, config_q};
            end else if (addr == soec_pkg::ADDR_STATUS) begin
               rdata_q[soec_pkg::STAT_BUSY_BIT] <= (state_q != SOEC_IDLE);
               rdata_q[soec_pkg::STAT_DONE_BIT] <= done_q;
               rdata_q[soec_pkg::STAT_PROG_BIT] <= sel_q;
            end
         end
      end
   end

   assign rdata = rdata_q;
   assign link.cfg_shift_strobe = strobe_q;
   assign link.program_select = sel_q;
   assign link.cfg_serial_in = sin_q;
endmodule : soec_host

/* logic/soec_pkg.sv */
package soec_pkg;
   localparam int unsigned CFG_BITS = 11;
   localparam int unsigned PAIR_COUNT = 10;
   localparam int unsigned CHOICE_BIT = 10;
   localparam logic [10:0] CFG_RESET = 11'h000;
   localparam logic [9:0] ALL_PAIRS_ON = 10'h3FF;
   // host register map (byte addresses)
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_CMD = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam int unsigned CMD_PROGRAM_BIT = 0;
   localparam int unsigned CMD_STANDARD_BIT = 1;
   localparam int unsigned CMD_CHOICE_BIT = 2;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;
   localparam int unsigned STAT_PROG_BIT = 2;
   // strobe timing
   localparam int unsigned REF_CLK_PERIOD_NS = 10;
   localparam int unsigned STROBE_MAX_RATE_MHZ = 100;
   localparam int unsigned STROBE_MIN_WIDTH_NS = 3;
   localparam int unsigned STROBE_MIN_PERIOD_NS = 1000 / STROBE_MAX_RATE_MHZ;
   localparam int unsigned HALF_BY_RATE = (STROBE_MIN_PERIOD_NS + 2 * REF_CLK_PERIOD_NS - 1)
      / (2 * REF_CLK_PERIOD_NS);
   localparam int unsigned HALF_BY_WIDTH = (STROBE_MIN_WIDTH_NS + REF_CLK_PERIOD_NS - 1)
      / REF_CLK_PERIOD_NS;
   localparam int unsigned HALF_CYC_MIN = (HALF_BY_RATE > HALF_BY_WIDTH) ?
      ((HALF_BY_RATE > 1) ? HALF_BY_RATE : 1) : ((HALF_BY_WIDTH > 1) ? HALF_BY_WIDTH : 1);
   localparam int unsigned LOAD_PULSE = CFG_BITS + 1;
endpackage : soec_pkg

/* logic/soec_if.sv */
`timescale 1ns/10ps
interface soec_if;
   logic cfg_shift_strobe;
   logic cfg_serial_in;
   logic program_select;
   modport dev (
      input cfg_shift_strobe,
      input cfg_serial_in,
      input program_select
   );
   modport host (
      output cfg_shift_strobe,
      output cfg_serial_in,
      output program_select
   );
endinterface : soec_if

/* logic/soec_dev.sv */
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - eleven-stage shift register plus control register
// - program high: strobe shifts serial bit in
// - eleven shifts, then one strobe loads control
// - first bit enables pair 9, bit 0
// - last bit bit 10 picks input clock
// - disabled pairs off, enabled carry chosen clock
// - strobe with program low resets everything
// - controller resets before each reload
// - one control load per reset only
// - program low: all pairs enabled, register ignored
// - program low: serial line picks clock directly
// - controller keeps strobe rate and width limits
module soec_dev (
   // link, clocked by the strobe
   soec_if.dev link,
   input wire logic rst,
   input wire logic clk_en,
   // clocks to distribute
   input wire logic ref_input_a,
   input wire logic ref_input_b,
   // distributed outputs and their state
   output logic [9:0] out_pair_n,
   output logic [9:0] out_enable,
   output logic input_choice,
   output logic loaded
);
   typedef enum logic [0:0] {
      SOEC_SHIFTING = 1'b0,
      SOEC_LOCKED = 1'b1
   } soec_dev_state_t;

   soec_dev_state_t state_q;
   logic [10:0] shift_q;
   logic [10:0] ctrl_q;
   logic [3:0] count_q;

   //////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge link.cfg_shift_strobe or posedge rst) begin
      if (rst) begin
         shift_q <= soec_pkg::CFG_RESET;
      end else if (clk_en) begin
         if (!link.program_select) begin
            shift_q <= soec_pkg::CFG_RESET;
         end else if (state_q == SOEC_SHIFTING && count_q < 4'(soec_pkg::CFG_BITS)) begin
            shift_q <= {link.cfg_serial_in, shift_q[10:1]};
         end
      end
   end

   always_ff @(posedge link.cfg_shift_strobe or posedge rst) begin
      if (rst) begin
         count_q <= 4'h0;
         state_q <= SOEC_SHIFTING;
      end else if (clk_en) begin
         if (!link.program_select) begin
            count_q <= 4'h0;
            state_q <= SOEC_SHIFTING;
         end else begin
            case (state_q)
               SOEC_SHIFTING: begin
                  if (count_q < 4'(soec_pkg::CFG_BITS)) begin
                     count_q <= count_q + 4'h1;
                  end else begin
                     state_q <= SOEC_LOCKED;
                  end
               end
               SOEC_LOCKED: begin
                  state_q <= SOEC_LOCKED;
               end
               default: begin
                  state_q <= SOEC_SHIFTING;
               end
            endcase
         end
      end
   end

   always_ff @(posedge link.cfg_shift_strobe or posedge rst) begin
      if (rst) begin
         ctrl_q <= soec_pkg::CFG_RESET;
      end else if (clk_en) begin
         if (!link.program_select) begin
            ctrl_q <= soec_pkg::CFG_RESET;
         end else if (state_q == SOEC_SHIFTING && count_q == 4'(soec_pkg::CFG_BITS)) begin
            ctrl_q <= shift_q;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // standard mode bypasses the register without any strobe
   always_comb begin
      if (!link.program_select) begin
         out_enable = soec_pkg::ALL_PAIRS_ON;
         input_choice = link.cfg_serial_in;
      end else begin
         out_enable = ctrl_q[9:0];
         input_choice = ctrl_q[soec_pkg::CHOICE_BIT];
      end
      loaded = (state_q == SOEC_LOCKED);
   end

   always_comb begin
      for (int i = 0; i < 10; i++) begin
         // pair i enable sits at bit 9-i
         out_pair_n[i] = out_enable[9 - i] & (input_choice ? ref_input_b : ref_input_a);
      end
   end
endmodule : soec_dev

/* sim/soec_assertions.sv */
`timescale 1ns/10ps
module soec_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link
   input wire logic cfg_shift_strobe,
   input wire logic cfg_serial_in,
   input wire logic program_select,
   // device state
   input wire logic [9:0] out_enable,
   input wire logic input_choice,
   input wire logic loaded
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   property p_std_all; !program_select |-> out_enable == 10'h3FF; endproperty
   a_std_all: assert property (p_std_all)
      else $error("pair disabled in standard mode");
   property p_std_choice; !program_select |-> input_choice == cfg_serial_in; endproperty
   a_std_choice: assert property (p_std_choice)
      else $error("standard mode choice not following serial line");
   property p_unload; program_select && !loaded |-> out_enable == 10'h000; endproperty
   a_unload: assert property (p_unload)
      else $error("pair enabled before load");
   property p_clean;
      $rose(program_select) |-> !loaded && out_enable == 10'h000 && !input_choice;
   endproperty
   a_clean: assert property (p_clean)
      else $error("state not cleared before programming");
   property p_rise_prog; $rose(loaded) |-> program_select; endproperty
   a_rise_prog: assert property (p_rise_prog)
      else $error("load outside programmed mode");
   property p_lock;
      loaded && $past(loaded) && program_select && $past(program_select)
         |-> $stable(out_enable) && $stable(input_choice);
   endproperty
   a_lock: assert property (p_lock)
      else $error("control changed after load");
   property p_width; $rose(cfg_shift_strobe) |=> cfg_shift_strobe; endproperty
   a_width: assert property (p_width)
      else $error("strobe pulse too short");
   property p_hold;
      cfg_shift_strobe && $past(cfg_shift_strobe) |-> $stable(cfg_serial_in) && $stable(program_select);
   endproperty
   a_hold: assert property (p_hold)
      else $error("serial or mode moved while strobe high");
endmodule : soec_assertions

/* sim/serial_output_enable_config_test.sv */
`timescale 1ns/10ps
module serial_output_enable_config_test;
   typedef struct packed {logic [10:0] cfg; logic [9:0] en; logic [9:0] pair; logic ch;} soec_row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic [9:0] out_pair_n;
   logic [9:0] out_enable;
   logic input_choice;
   logic loaded;
   logic ref_a = 1'b1;
   logic ref_b = 1'b0;
   int miscompares = 0;
   int checked = 0;
   // pair i enable sits at config bit 9-i; input a high, input b low
   soec_row_t rows [5] = '{'{11'h001, 10'h001, 10'h200, 1'b0}, '{11'h200, 10'h200, 10'h001, 1'b0},
      '{11'h155, 10'h155, 10'h2AA, 1'b0}, '{11'h7FF, 10'h3FF, 10'h000, 1'b1},
      '{11'h000, 10'h000, 10'h000, 1'b0}};
   soec_if link ();
   soec_host #(.HALF_CYC(2)) soec_host_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
   soec_dev soec_dev_inst (.link(link), .rst(rst), .clk_en(1'b1), .ref_input_a(ref_a),
      .ref_input_b(ref_b), .out_pair_n(out_pair_n), .out_enable(out_enable),
      .input_choice(input_choice), .loaded(loaded));
   soec_assertions soec_assertions_inst (.ref_clk(ref_clk), .rst(rst),
      .cfg_shift_strobe(link.cfg_shift_strobe), .cfg_serial_in(link.cfg_serial_in),
      .program_select(link.program_select), .out_enable(out_enable),
      .input_choice(input_choice), .loaded(loaded));
   initial forever #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
      end
   endtask : chk
   task print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [3:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : rd_reg
   task wait_done;
      int n;
      n = 0;
      rd_reg(soec_pkg::ADDR_STATUS);
      while (rv[soec_pkg::STAT_DONE_BIT] !== 1'b1 && n < 100) begin
         rd_reg(soec_pkg::ADDR_STATUS);
         n++;
      end
      // a spent limit counts once; the run still reaches the verdict
      if (rv[soec_pkg::STAT_DONE_BIT] !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t sequence never finished", $time);
      end
   endtask : wait_done
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(soec_pkg::ADDR_CONFIG, {21'h0, rows[i].cfg});
         rd_reg(soec_pkg::ADDR_CONFIG);
         chk(rv, {21'h0, rows[i].cfg}, "config readback");
         wr_reg(soec_pkg::ADDR_CMD, 32'h1);
         rd_reg(soec_pkg::ADDR_STATUS);
         chk(rv[soec_pkg::STAT_BUSY_BIT], 1'b1, "busy during sequence");
         wait_done();
         chk(out_enable, rows[i].en, "enable map");
         chk(out_pair_n, rows[i].pair, "pair outputs");
         chk(input_choice, rows[i].ch, "input choice");
         chk(loaded, 1'b1, "loaded flag");
         chk(rv[soec_pkg::STAT_PROG_BIT], 1'b1, "mode bit after load");
         $display("row %0d done", i);
      end
      for (int c = 0; c < 2; c++) begin
         wr_reg(soec_pkg::ADDR_CMD, {29'h0, c[0], 2'h2});
         rd_reg(soec_pkg::ADDR_STATUS);
         chk(rv[soec_pkg::STAT_PROG_BIT], 1'b0, "mode bit");
         chk(out_enable, 10'h3FF, "standard enables");
         chk(input_choice, c[0], "standard choice");
         chk(out_pair_n, c[0] ? 10'h000 : 10'h3FF, "standard pairs");
         // swap the input levels so the chosen clock, not a constant, is seen
         @(posedge ref_clk);
         ref_a <= 1'b0;
         ref_b <= 1'b1;
         @(posedge ref_clk);
         #1 chk(out_pair_n, c[0] ? 10'h3FF : 10'h000, "swapped inputs");
         @(posedge ref_clk);
         ref_a <= 1'b1;
         ref_b <= 1'b0;
         $display("standard mode %0d done", c);
      end
      rd_reg(4'hC);
      chk(rv, 32'h0, "unmapped read");
      $display("unmapped read done");
      // reset in the middle of a sequence, then program again
      wr_reg(soec_pkg::ADDR_CONFIG, 32'h0000_07FF);
      wr_reg(soec_pkg::ADDR_CMD, 32'h1);
      repeat (20) @(posedge ref_clk);
      chk(link.program_select, 1'b1, "mode mid sequence");
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 chk(loaded, 1'b0, "loaded after reset");
      chk(link.program_select, 1'b0, "mode after reset");
      chk(link.cfg_shift_strobe, 1'b0, "strobe after reset");
      chk(out_enable, 10'h3FF, "enables after reset");
      @(posedge ref_clk);
      rst <= 1'b0;
      rd_reg(soec_pkg::ADDR_STATUS);
      chk(rv, 32'h0, "status after reset");
      rd_reg(soec_pkg::ADDR_CONFIG);
      chk(rv, 32'h0, "config after reset");
      wr_reg(soec_pkg::ADDR_CONFIG, 32'h0000_0401);
      wr_reg(soec_pkg::ADDR_CMD, 32'h1);
      wait_done();
      chk(out_enable, 10'h001, "enables after reprogram");
      chk(input_choice, 1'b1, "choice after reprogram");
      chk(loaded, 1'b1, "loaded after reprogram");
      $display("reset test done");
      print_verdict();
   end
endmodule : serial_output_enable_config_test
